//--- logic/emcfg_fifo.sv
`timescale 1ns/10ps
module emcfg_fifo #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // filling and draining sides
   emcfg_stream_if.snk push,
   emcfg_stream_if.src pop
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp_q;
   logic [AW:0] rp_q;
   logic full;
   logic empty;

   assign empty = (wp_q == rp_q);
   assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   assign push.ready = !full;
   assign pop.valid = !empty;
   assign pop.data = mem[rp_q[AW-1:0]];

   always_ff @(posedge sys_clk) begin
      if (push.valid && !full) begin
         mem[wp_q[AW-1:0]] <= push.data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wp_q <= '0;
      end else if (push.valid && !full) begin
         wp_q <= wp_q + 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rp_q <= '0;
      end else if (pop.ready && !empty) begin
         rp_q <= rp_q + 1'b1;
      end
   end
endmodule : emcfg_fifo

//--- logic/emcfg_map.sv
`timescale 1ns/10ps
`include "emcfg_regs.svh"
module emcfg_map (
   // configuration
   input wire logic [1:0] mode,
   input wire logic fifo_map,
   // effective address
   input wire logic [15:0] addr,
   // decode result
   output emcfg_pkg::emcfg_target_e target,
   output logic [15:0] loc_addr
);
   function automatic logic in_fifo_window(input logic [15:0] a);
      in_fifo_window = (a >= `EMCFG_FIFO_BASE) && (a <= `EMCFG_FIFO_LAST);
   endfunction : in_fifo_window

   function automatic logic above_onchip(input logic [15:0] a);
      above_onchip = (a & ~`EMCFG_ONCHIP_MASK) != 16'h0000;
   endfunction : above_onchip

   always_comb begin
      target = emcfg_pkg::TGT_OFFCHIP;
      loc_addr = addr & `EMCFG_ONCHIP_MASK;
      if (fifo_map && in_fifo_window(addr)) begin
         // fifo ram hides whatever normally sits in the window
         target = emcfg_pkg::TGT_USBFIFO;
         loc_addr = addr & `EMCFG_FIFO_OFS_MASK;
      end else begin
         case (mode)
            `EMCFG_MODE_ONCHIP: begin
               target = emcfg_pkg::TGT_ONCHIP;
            end
            `EMCFG_MODE_SPLIT_NOBANK, `EMCFG_MODE_SPLIT_BANK: begin
               if (above_onchip(addr)) begin
                  target = emcfg_pkg::TGT_OFFCHIP;
               end else begin
                  target = emcfg_pkg::TGT_ONCHIP;
               end
            end
            default: begin
               target = emcfg_pkg::TGT_OFFCHIP;
            end
         endcase
      end
   end
endmodule : emcfg_map

//--- logic/emcfg_pkg.sv
package emcfg_pkg;

   // transfer sequencer states
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001,
      ST_DECODE = 9'h002,
      ST_LOCAL = 9'h004,
      ST_ALE_HI = 9'h008,
      ST_ALE_LO = 9'h010,
      ST_ADDR = 9'h020,
      ST_STROBE = 9'h040,
      ST_HOLD = 9'h080,
      ST_DONE = 9'h100
   } emcfg_state_e;

   // where an access lands
   typedef enum logic [2:0] {
      TGT_ONCHIP = 3'h1,
      TGT_USBFIFO = 3'h2,
      TGT_OFFCHIP = 3'h4
   } emcfg_target_e;

   // one queued external data move
   typedef struct packed {
      logic write;
      logic short_form;
      logic [15:0] addr;
      logic [7:0] wdata;
   } emcfg_req_s;

endpackage : emcfg_pkg

//--- logic/emcfg_regs.svh
`ifndef EMCFG_REGS_SVH
`define EMCFG_REGS_SVH

// configuration register location, reset value and writable bits
`define EMCFG_CFG_ADDR 8'h85
`define EMCFG_CFG_RESET 8'h03
`define EMCFG_CFG_WMASK 8'h5F

// configuration register fields
`define EMCFG_FIFO_MAP_BIT 6
`define EMCFG_MUX_SEL_BIT 4
`define EMCFG_MODE_HI 3
`define EMCFG_MODE_LO 2
`define EMCFG_ALEW_HI 1
`define EMCFG_ALEW_LO 0

// memory mode encodings
`define EMCFG_MODE_ONCHIP 2'h0
`define EMCFG_MODE_SPLIT_NOBANK 2'h1
`define EMCFG_MODE_SPLIT_BANK 2'h2
`define EMCFG_MODE_OFFCHIP 2'h3

// on-chip data ram size and usb fifo window
`define EMCFG_ONCHIP_MASK 16'h0FFF
`define EMCFG_FIFO_BASE 16'h0400
`define EMCFG_FIFO_LAST 16'h07FF
`define EMCFG_FIFO_OFS_MASK 16'h03FF

// request queue geometry
`define EMCFG_REQ_WIDTH 26
`define EMCFG_REQ_DEPTH 32

`endif

//--- logic/emcfg_stream_if.sv
`timescale 1ns/10ps
interface emcfg_stream_if #(
   parameter int WIDTH = 26
) ();
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;

   modport src (
      output valid,
      output data,
      input ready
   );

   modport snk (
      input valid,
      input data,
      output ready
   );
endinterface : emcfg_stream_if

//--- logic/emcfg_top.sv
`timescale 1ns/10ps
`include "emcfg_regs.svh"
// Overview of operation
// - multiplex select bit picks shared pins (0) or separate pins (1).
// - shared mode carries data and low address on the same eight pins.
// - device makes the latch strobe; external latch holds low address.
// - first phase holds strobe high while low address is on pins.
// - strobe falling starts phase two; latch outputs then stay frozen.
// - later in phase two the pins carry data during read/write strobe.
// - separate mode uses dedicated address and data pins, no latch phase.
// - fifo map bit with fast usb clock maps fifo ram at 0x0400-0x07FF.
// - memory mode field picks on-chip, split, split with bank, off-chip.
// - latch pulse width is programmable in system clock periods.
// - shared transfer adds two latch cycles, eight cycles minimum.
module emcfg_top (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // special function register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // external data move requests
   input wire logic req_valid,
   output logic req_ready,
   input wire logic req_write,
   input wire logic req_short_form,
   input wire logic [15:0] req_addr,
   input wire logic [7:0] req_wdata,
   // completion
   output logic rsp_valid,
   output logic [7:0] rsp_rdata,
   // on-chip and usb fifo ram access
   output logic loc_valid,
   output logic loc_fifo,
   output logic loc_write,
   output logic [15:0] loc_addr,
   output logic [7:0] loc_wdata,
   input wire logic [7:0] loc_rdata,
   // usb clock at least twice the system clock
   input wire logic usb_clk_fast,
   // shared address/data or data pins
   input wire logic [7:0] ad_in,
   output logic [7:0] ad_out,
   output logic ad_oe_n,
   // dedicated low address pins
   output logic [7:0] addr_lo_out,
   output logic addr_lo_oe_n,
   // high address pins
   output logic [7:0] addr_hi_out,
   output logic addr_hi_oe_n,
   // strobes
   output logic ale,
   output logic rd_n,
   output logic wr_n
);
   emcfg_pkg::emcfg_state_e state_q;
   emcfg_pkg::emcfg_state_e state_d;
   emcfg_pkg::emcfg_target_e tgt_q;
   emcfg_pkg::emcfg_target_e map_tgt;
   emcfg_pkg::emcfg_req_s cur_q;

   logic [7:0] cfg_q;
   logic [7:0] sfr_rdata_q;
   logic usb_fast_s1_q;
   logic usb_fast_s2_q;
   logic [7:0] ad_s1_q;
   logic [7:0] ad_s2_q;
   logic fifo_map;
   logic [1:0] mode;
   logic [15:0] map_addr;
   logic [15:0] loc_addr_q;
   logic shared_q;
   logic hi_drive_q;
   logic [1:0] alew_q;
   logic [1:0] cnt_q;
   logic rsp_valid_q;
   logic [7:0] rsp_rdata_q;
   logic ale_phase;
   logic data_phase;
   logic pins_active;

   emcfg_stream_if #(.WIDTH(`EMCFG_REQ_WIDTH)) push_if ();
   emcfg_stream_if #(.WIDTH(`EMCFG_REQ_WIDTH)) pop_if ();

   // request queue
   assign push_if.valid = req_valid;
   assign push_if.data = {req_write, req_short_form, req_addr, req_wdata};
   assign req_ready = push_if.ready;
   assign pop_if.ready = (state_q == emcfg_pkg::ST_IDLE);

   emcfg_fifo #(
      .WIDTH(`EMCFG_REQ_WIDTH),
      .DEPTH(`EMCFG_REQ_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .reset(reset),
      .push(push_if),
      .pop(pop_if)
   );

   // configuration register
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cfg_q <= `EMCFG_CFG_RESET;
      end else if (sfr_wr && (sfr_addr == `EMCFG_CFG_ADDR)) begin
         cfg_q <= sfr_wdata & `EMCFG_CFG_WMASK;
      end
   end

   // read data follows the address by one cycle; unused bits read zero
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sfr_rdata_q <= 8'h00;
      end else if (sfr_addr == `EMCFG_CFG_ADDR) begin
         sfr_rdata_q <= cfg_q & `EMCFG_CFG_WMASK;
      end else begin
         sfr_rdata_q <= 8'h00;
      end
   end

   assign sfr_rdata = sfr_rdata_q;

   // usb clock status arrives from another domain
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         usb_fast_s1_q <= 1'b0;
         usb_fast_s2_q <= 1'b0;
      end else begin
         usb_fast_s1_q <= usb_clk_fast;
         usb_fast_s2_q <= usb_fast_s1_q;
      end
   end

   // read data pins are asynchronous to the system clock
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ad_s1_q <= 8'h00;
         ad_s2_q <= 8'h00;
      end else begin
         ad_s1_q <= ad_in;
         ad_s2_q <= ad_s1_q;
      end
   end

   // address decode
   assign fifo_map = cfg_q[`EMCFG_FIFO_MAP_BIT] && usb_fast_s2_q;
   assign mode = cfg_q[`EMCFG_MODE_HI:`EMCFG_MODE_LO];

   emcfg_map u_map (
      .mode(mode),
      .fifo_map(fifo_map),
      .addr(cur_q.addr),
      .target(map_tgt),
      .loc_addr(map_addr)
   );

   // request capture
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cur_q <= '0;
      end else if (pop_if.ready && pop_if.valid) begin
         cur_q <= pop_if.data;
      end
   end

   // configuration is frozen for the length of one transfer
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         tgt_q <= emcfg_pkg::TGT_ONCHIP;
         loc_addr_q <= 16'h0000;
         shared_q <= 1'b1;
         hi_drive_q <= 1'b0;
         alew_q <= 2'h0;
      end else if (state_q == emcfg_pkg::ST_DECODE) begin
         tgt_q <= map_tgt;
         loc_addr_q <= map_addr;
         shared_q <= !cfg_q[`EMCFG_MUX_SEL_BIT];
         alew_q <= cfg_q[`EMCFG_ALEW_HI:`EMCFG_ALEW_LO];
         // short form leaves upper pins to the port latches except in split bank mode
         hi_drive_q <= !cur_q.short_form ||
                       (mode == `EMCFG_MODE_SPLIT_BANK);
      end
   end

   // transfer sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         emcfg_pkg::ST_IDLE: begin
            if (pop_if.valid) begin
               state_d = emcfg_pkg::ST_DECODE;
            end
         end
         emcfg_pkg::ST_DECODE: begin
            if (map_tgt != emcfg_pkg::TGT_OFFCHIP) begin
               state_d = emcfg_pkg::ST_LOCAL;
            end else if (!cfg_q[`EMCFG_MUX_SEL_BIT]) begin
               state_d = emcfg_pkg::ST_ALE_HI;
            end else begin
               state_d = emcfg_pkg::ST_ADDR;
            end
         end
         emcfg_pkg::ST_LOCAL: begin
            state_d = emcfg_pkg::ST_IDLE;
         end
         emcfg_pkg::ST_ALE_HI: begin
            if (cnt_q == alew_q) begin
               state_d = emcfg_pkg::ST_ALE_LO;
            end
         end
         emcfg_pkg::ST_ALE_LO: begin
            if (cnt_q == alew_q) begin
               state_d = emcfg_pkg::ST_ADDR;
            end
         end
         emcfg_pkg::ST_ADDR: begin
            state_d = emcfg_pkg::ST_STROBE;
         end
         emcfg_pkg::ST_STROBE: begin
            state_d = emcfg_pkg::ST_HOLD;
         end
         emcfg_pkg::ST_HOLD: begin
            state_d = emcfg_pkg::ST_DONE;
         end
         emcfg_pkg::ST_DONE: begin
            state_d = emcfg_pkg::ST_IDLE;
         end
         default: begin
            state_d = emcfg_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_q <= emcfg_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // latch pulse width counter, field value plus one clocks per phase
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cnt_q <= 2'h0;
      end else if (ale_phase && (cnt_q != alew_q)) begin
         cnt_q <= cnt_q + 2'h1;
      end else begin
         cnt_q <= 2'h0;
      end
   end

   // completion, read data taken two clocks after the strobe
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rsp_valid_q <= 1'b0;
      end else begin
         rsp_valid_q <= (state_q == emcfg_pkg::ST_LOCAL) ||
                        (state_q == emcfg_pkg::ST_DONE);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (reset) begin
         rsp_rdata_q <= 8'h00;
      end else if ((state_q == emcfg_pkg::ST_LOCAL) && !cur_q.write) begin
         rsp_rdata_q <= loc_rdata;
      end else if ((state_q == emcfg_pkg::ST_DONE) && !cur_q.write) begin
         rsp_rdata_q <= ad_s2_q;
      end
   end

   assign rsp_valid = rsp_valid_q;
   assign rsp_rdata = rsp_rdata_q;

   // on-chip and usb fifo ram access
   assign loc_valid = (state_q == emcfg_pkg::ST_LOCAL);
   assign loc_fifo = (tgt_q == emcfg_pkg::TGT_USBFIFO);
   assign loc_write = cur_q.write;
   assign loc_addr = loc_addr_q;
   assign loc_wdata = cur_q.wdata;

   // pin phases
   assign ale_phase = (state_q == emcfg_pkg::ST_ALE_HI) ||
                      (state_q == emcfg_pkg::ST_ALE_LO);
   assign data_phase = (state_q == emcfg_pkg::ST_ADDR) ||
                       (state_q == emcfg_pkg::ST_STROBE) ||
                       (state_q == emcfg_pkg::ST_HOLD);
   assign pins_active = ale_phase || data_phase;

   // latch strobe high only in the first phase
   assign ale = (state_q == emcfg_pkg::ST_ALE_HI);

   // shared pins: low address through both latch strobe phases, then write data
   assign ad_out = ale_phase ? cur_q.addr[7:0] : cur_q.wdata;
   assign ad_oe_n = !(ale_phase || (data_phase && cur_q.write));

   // dedicated low address pins only when the bus is not shared
   assign addr_lo_out = cur_q.addr[7:0];
   assign addr_lo_oe_n = !(data_phase && !shared_q);

   assign addr_hi_out = cur_q.addr[15:8];
   assign addr_hi_oe_n = !(pins_active && hi_drive_q);

   // read and write strobes in the data part of the transfer
   assign rd_n = !((state_q == emcfg_pkg::ST_STROBE) && !cur_q.write);
   assign wr_n = !((state_q == emcfg_pkg::ST_STROBE) && cur_q.write);
endmodule : emcfg_top

//--- test/emcfg_checker.sv
`timescale 1ns/10ps
module emcfg_checker (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   // status and pins
   input wire logic rsp_valid,
   input wire logic loc_valid,
   input wire logic ad_oe_n,
   input wire logic addr_lo_oe_n,
   input wire logic ale,
   input wire logic rd_n,
   input wire logic wr_n
);
   logic [7:0] cfg_q;
   logic [2:0] hi_q;
   logic [2:0] lo_q;
   logic [2:0] w;
   assign w = {1'b0, cfg_q[1:0]} + 3'h1;
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cfg_q <= 8'h03;
      end else if (sfr_wr && sfr_addr == 8'h85) begin
         cfg_q <= sfr_wdata & 8'h5F;
      end
   end
   // cycles of strobe high, and cycles since it fell
   always_ff @(posedge sys_clk) begin
      hi_q <= ale ? hi_q + 3'h1 : 3'h0;
   end
   always_ff @(posedge sys_clk) begin
      if (reset || (!ale && lo_q == 3'h7)) begin
         lo_q <= 3'h7;
      end else begin
         lo_q <= ale ? 3'h0 : lo_q + 3'h1;
      end
   end
   default clocking dc @(posedge sys_clk); endclocking
   default disable iff (reset);
   sequence strobe_s;
      (!rd_n || !wr_n) ##1 (rd_n && wr_n);
   endsequence
   ale_drive_a: assert property (ale |-> !ad_oe_n && rd_n && wr_n)
      else $error("latch strobe high without address driven");
   ale_high_a: assert property ($fell(ale) |-> hi_q == w)
      else $error("latch strobe high time wrong");
   ale_low_a: assert property ($fell(rd_n && wr_n) && !cfg_q[4]
      |-> lo_q == w + 3'h1) else $error("latch strobe low time wrong");
   write_drive_a: assert property (!wr_n |-> !ad_oe_n)
      else $error("write data not driven");
   read_float_a: assert property (!rd_n |-> ad_oe_n)
      else $error("pins driven during read");
   sep_addr_a: assert property (cfg_q[4] && !(rd_n && wr_n)
      |-> !addr_lo_oe_n) else $error("low address pins idle");
   sep_no_ale_a: assert property (cfg_q[4] |-> !ale)
      else $error("latch strobe in separate mode");
   mux_lo_idle_a: assert property (!cfg_q[4] |-> addr_lo_oe_n)
      else $error("low address pins driven in shared mode");
   strobe_rsp_a: assert property ($fell(rd_n && wr_n)
      |-> strobe_s ##2 rsp_valid) else $error("transfer tail wrong");
   local_rsp_a: assert property (loc_valid
      |-> ad_oe_n && rd_n && wr_n ##1 rsp_valid) else $error("local late");
   reg_read_a: assert property (sfr_rdata ==
      ($past(sfr_addr) == 8'h85 && !$past(reset) ? $past(cfg_q) : 8'h00))
      else $error("register read value wrong");
endmodule : emcfg_checker
bind emcfg_top emcfg_checker emcfg_checker_inst (.sys_clk, .reset,
   .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .rsp_valid, .loc_valid,
   .ad_oe_n, .addr_lo_oe_n, .ale, .rd_n, .wr_n);

//--- test/emcfg_mem_model.sv
`timescale 1ns/10ps
module emcfg_mem_model (
   // clock
   input wire logic sys_clk,
   // device pins
   input wire logic [7:0] ad_out,
   input wire logic [7:0] addr_lo_out,
   input wire logic addr_lo_oe_n,
   input wire logic [7:0] addr_hi_out,
   input wire logic addr_hi_oe_n,
   input wire logic ale,
   input wire logic rd_n,
   input wire logic wr_n,
   // read data
   output logic [7:0] ad_in
);
   logic [7:0] mem [65536];
   logic [7:0] lat_q = 8'h00;
   logic [7:0] rdat_q = 8'h00;
   logic hold_q = 1'b0;
   logic [15:0] a;
   // latch follows the shared pins only while the strobe is high
   always @(posedge sys_clk) if (ale) lat_q <= ad_out;
   assign a = {addr_hi_oe_n ? 8'h00 : addr_hi_out,
      addr_lo_oe_n ? lat_q : addr_lo_out};
   always @(posedge sys_clk) begin
      hold_q <= !rd_n;
      if (!rd_n) rdat_q <= mem[a];
      if (!wr_n) mem[a] <= ad_out;
   end
   // data held one cycle past the strobe, released pins show the inverse
   assign ad_in = hold_q ? rdat_q : (!rd_n ? mem[a] : ~rdat_q);
endmodule : emcfg_mem_model

//--- test/emcfg_top_tb.sv
`timescale 1ns/10ps
module emcfg_top_tb;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic req_short_form = 1'b0;
   logic [15:0] req_addr = 16'h0000;
   logic [7:0] req_wdata = 8'h00;
   logic usb_clk_fast = 1'b0;
   logic [7:0] sfr_rdata, rsp_rdata, loc_wdata, loc_rdata, ad_in, ad_out;
   logic [7:0] addr_lo_out, addr_hi_out, g_rd;
   logic [15:0] loc_addr, g_laddr;
   logic [8:0] g_lwd;
   logic req_ready, rsp_valid, loc_valid, loc_fifo, loc_write, ad_oe_n;
   logic addr_lo_oe_n, addr_hi_oe_n, ale, rd_n, wr_n, g_loc, g_fifo, g_hi;
   int errors = 0;
   int checked = 0;
   int rsp_count = 0;
   int g_ale;
   assign loc_rdata = loc_addr[7:0] ^ 8'hA5;
   emcfg_top emcfg_top_inst (.sys_clk, .reset, .sfr_addr, .sfr_wr,
      .sfr_wdata, .sfr_rdata, .req_valid, .req_ready, .req_write,
      .req_short_form, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata,
      .loc_valid, .loc_fifo, .loc_write, .loc_addr, .loc_wdata, .loc_rdata,
      .usb_clk_fast, .ad_in, .ad_out, .ad_oe_n, .addr_lo_out, .addr_lo_oe_n,
      .addr_hi_out, .addr_hi_oe_n, .ale, .rd_n, .wr_n);
   emcfg_mem_model emcfg_mem_model_inst (.sys_clk, .ad_out, .addr_lo_out,
      .addr_lo_oe_n, .addr_hi_out, .addr_hi_oe_n, .ale, .rd_n, .wr_n,
      .ad_in);
   initial forever #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (rsp_valid === 1'b1) rsp_count <= rsp_count + 1;
   task complete_run;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task cfg_wr(input logic [7:0] d);
      @(posedge sys_clk);
      sfr_addr <= 8'h85;
      sfr_wr <= 1'b1;
      sfr_wdata <= d;
      @(posedge sys_clk);
      sfr_wr <= 1'b0;
   endtask : cfg_wr
   task cfg_rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      sfr_addr <= a;
      repeat (2) @(posedge sys_clk);
      d = sfr_rdata;
   endtask : cfg_rd
   task xfer(input logic w, s, input logic [15:0] a, input logic [7:0] d);
      int i;
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_short_form <= s;
      req_addr <= a;
      req_wdata <= d;
      g_ale = 0;
      g_loc = 1'b0;
      g_hi = 1'b1;
      do @(posedge sys_clk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      for (i = 0; i < 60 && rsp_valid !== 1'b1; i++) begin
         @(posedge sys_clk);
         if (ale === 1'b1) g_ale++;
         if (rd_n === 1'b0 || wr_n === 1'b0) g_hi = addr_hi_oe_n;
         if (loc_valid === 1'b1) begin
            g_loc = 1'b1;
            g_fifo = loc_fifo;
            g_laddr = loc_addr;
            g_lwd = {loc_write, loc_wdata};
         end
      end
      g_rd = rsp_rdata;
      check(rsp_valid, 1'b1);
   endtask : xfer
   task test_regs;
      logic [7:0] d;
      cfg_rd(8'h85, d);
      check(d, 8'h03);
      cfg_rd(8'h84, d);
      check(d, 8'h00);
      cfg_wr(8'hFF);
      cfg_rd(8'h85, d);
      check(d, 8'h5F);
      // reset in mid-run brings the register back to its reset value
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      cfg_rd(8'h85, d);
      check(d, 8'h03);
      $display("test regs done");
   endtask : test_regs
   task test_mux;
      for (int k = 0; k < 4; k++) begin
         cfg_wr({6'h03, k[1:0]});
         xfer(1'b1, 1'b0, {14'h200D, k[1:0]}, {6'h16, k[1:0]});
         check(g_ale, k + 1);
         xfer(1'b0, 1'b0, {14'h200D, k[1:0]}, 8'h00);
         check(g_rd, {6'h16, k[1:0]});
         check(g_ale, k + 1);
         check(g_hi, 1'b0);
      end
      $display("test mux done");
   endtask : test_mux
   task test_sep;
      cfg_wr(8'h1F);
      xfer(1'b1, 1'b0, 16'h9100, 8'hC3);
      xfer(1'b0, 1'b0, 16'h9100, 8'h00);
      check(g_rd, 8'hC3);
      check(g_ale, 0);
      xfer(1'b1, 1'b1, 16'h1277, 8'h3C);
      xfer(1'b0, 1'b1, 16'h1277, 8'h00);
      check({g_hi, g_rd}, 9'h13C);
      cfg_wr(8'h18);
      xfer(1'b1, 1'b1, 16'h2277, 8'h96);
      xfer(1'b0, 1'b1, 16'h2277, 8'h00);
      check({g_hi, g_rd}, 9'h096);
      $display("test sep done");
   endtask : test_sep
   task test_map;
      cfg_wr(8'h04);
      xfer(1'b0, 1'b0, 16'h0123, 8'h00);
      check({g_loc, g_laddr, g_rd}, 25'h1012386);
      xfer(1'b1, 1'b0, 16'h1123, 8'h11);
      check({g_loc, g_ale[3:0]}, 5'h01);
      cfg_wr(8'h00);
      xfer(1'b0, 1'b0, 16'h3123, 8'h00);
      check({g_loc, g_laddr}, 17'h10123);
      xfer(1'b1, 1'b0, 16'h3123, 8'h5A);
      check({g_loc, g_lwd}, 10'h35A);
      cfg_wr(8'h44);
      xfer(1'b0, 1'b0, 16'h0456, 8'h00);
      check({g_fifo, g_laddr}, 17'h00456);
      @(posedge sys_clk);
      usb_clk_fast <= 1'b1;
      repeat (4) @(posedge sys_clk);
      xfer(1'b0, 1'b0, 16'h0456, 8'h00);
      check({g_fifo, g_laddr}, 17'h10056);
      cfg_wr(8'h4F);
      xfer(1'b0, 1'b0, 16'h07FF, 8'h00);
      check({g_loc, g_fifo, g_laddr}, 18'h303FF);
      xfer(1'b1, 1'b0, 16'h0800, 8'h21);
      check(g_loc, 1'b0);
      $display("test map done");
   endtask : test_map
   task test_queue;
      int i;
      int n;
      int base;
      n = 0;
      base = rsp_count;
      cfg_wr(8'h0F);
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_write <= 1'b1;
      req_addr <= 16'h9000;
      req_wdata <= 8'h77;
      for (i = 0; i < 200 && n == i; i++) begin
         @(posedge sys_clk);
         if (req_ready === 1'b1) n++;
      end
      req_valid <= 1'b0;
      // 32 queued plus three popped at one transfer per 14 clocks
      check(n, 35);
      for (i = 0; i < 1000 && rsp_count - base != n; i++) @(posedge sys_clk);
      check(rsp_count - base, n);
      $display("test queue done");
   endtask : test_queue
   initial begin
      repeat (8) @(posedge sys_clk);
      reset <= 1'b0;
      test_regs;
      test_mux;
      test_sep;
      test_map;
      test_queue;
      complete_run;
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      complete_run;
   end
endmodule : emcfg_top_tb
